// *** auto_reload_timer_two.sv ***
// auto-reload timer with 16-bit and split 8-bit modes
`timescale 1ns/1ps

// Operation
// - split select clear: both bytes form one 16-bit auto-reload up-counter
// - 16-bit rollover loads 16-bit reload value and sets high overflow flag
// - 16-bit mode: with timer irq enabled, request interrupt on every rollover
// - 16-bit mode: low-byte irq enable also requests interrupt on low wrap
// - split select set: two independent 8-bit counters, each own reload byte
// - split mode: run bit gates high byte only, low byte always counts
// - per-byte system_clock select (16-bit mode uses the low-byte one), else ext select picks system_clock/12 or external/8
// - external/8 clock synchronised to system clock before use as enable
// - split mode: high wrap sets high flag, low wrap sets low flag
// - split mode irq on high overflow, or either with low irq enable
// - overflow flags never cleared by hardware, only by software writes
module auto_reload_timer_two (
    input  wire  logic       core_clk_in,
    input  wire  logic       reset_n_in,
    input  wire  logic [7:0] sfr_addr_in,
    input  wire  logic       sfr_wr_in,
    input  wire  logic [7:0] sfr_wdata_in,
    output logic       [7:0] sfr_rdata_out,
    input  wire  logic       high_byte_system_clock_select_in,
    input  wire  logic       low_byte_system_clock_select_in,
    input  wire  logic       timer_irq_enable_in,
    input  wire  logic       ext_clock_in,
    output logic             irq_request_out,
    output logic             high_overflow_flag_out,
    output logic             low_overflow_flag_out
);
    import timer_two_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    timer_state_t st_r;
    timer_state_t st_nxt;

    logic        wr_ctl;
    logic        wr_lo;
    logic        wr_hi;
    logic        div12_tick;
    logic        ext_tick;
    logic        tick_lo;
    logic        tick_hi;
    logic        set_high;
    logic        set_low;
    logic [15:0] count16;

    always_comb begin
        st_nxt     = st_r;
        set_high   = 1'b0;
        set_low    = 1'b0;
        count16    = {st_r.count_high_byte, st_r.count_low_byte};
        wr_ctl     = sfr_wr_in && (sfr_addr_in == TIMER_CONTROL_ADDR);
        wr_lo      = sfr_wr_in && (sfr_addr_in == COUNT_LOW_BYTE_ADDR);
        wr_hi      = sfr_wr_in && (sfr_addr_in == COUNT_HIGH_BYTE_ADDR);

        // --------------------------------------------------------
        // count clock sources
        // --------------------------------------------------------
        // system_clock / 12 prescaler
        div12_tick = (st_r.presc == PRESCALE_LAST);
        st_nxt.presc = div12_tick ? PRESCALE_RESET : st_r.presc + 4'h1;

        // sync then divide
        // only the second stage feeds the edge detector
        st_nxt.ext_meta = ext_clock_in;
        st_nxt.ext_sync = st_r.ext_meta;
        st_nxt.ext_prev = st_r.ext_sync;
        ext_tick = 1'b0;
        if (st_r.ext_sync && !st_r.ext_prev) begin
            st_nxt.ext_div = st_r.ext_div + 3'h1;
            ext_tick       = (st_r.ext_div == 3'h7);
        end

        tick_lo = low_byte_system_clock_select_in ? 1'b1 :
                  (st_r.ctl.ext_clock_select ? ext_tick : div12_tick);
        tick_hi = high_byte_system_clock_select_in ? 1'b1 :
                  (st_r.ctl.ext_clock_select ? ext_tick : div12_tick);

        // --------------------------------------------------------
        // counting
        // --------------------------------------------------------
        if (!st_r.ctl.split_mode_select) begin
            // one 16-bit counter, gated by run bit
            if (st_r.ctl.run_control && tick_lo) begin
                set_low = (st_r.count_low_byte == BYTE_MAX);
                if (count16 == {BYTE_MAX, BYTE_MAX}) begin
                    set_high = 1'b1;
                    st_nxt.count_low_byte  = st_r.reload_low_byte;
                    st_nxt.count_high_byte = st_r.reload_high_byte;
                end else begin
                    {st_nxt.count_high_byte, st_nxt.count_low_byte} = count16 + 16'h0001;
                end
            end
        end else begin
            if (tick_lo) begin
                if (st_r.count_low_byte == BYTE_MAX) begin
                    set_low = 1'b1;
                    st_nxt.count_low_byte = st_r.reload_low_byte;
                end else begin
                    st_nxt.count_low_byte = st_r.count_low_byte + 8'h01;
                end
            end
            // high byte gated by run bit
            if (st_r.ctl.run_control && tick_hi) begin
                if (st_r.count_high_byte == BYTE_MAX) begin
                    set_high = 1'b1;
                    st_nxt.count_high_byte = st_r.reload_high_byte;
                end else begin
                    st_nxt.count_high_byte = st_r.count_high_byte + 8'h01;
                end
            end
        end

        // --------------------------------------------------------
        // register writes and flags
        // --------------------------------------------------------
        // software writes to the counter win over counting
        if (wr_lo) begin
            st_nxt.count_low_byte = sfr_wdata_in;
        end
        if (wr_hi) begin
            st_nxt.count_high_byte = sfr_wdata_in;
        end
        if (sfr_wr_in && (sfr_addr_in == RELOAD_LOW_BYTE_ADDR)) begin
            st_nxt.reload_low_byte = sfr_wdata_in;
        end
        if (sfr_wr_in && (sfr_addr_in == RELOAD_HIGH_BYTE_ADDR)) begin
            st_nxt.reload_high_byte = sfr_wdata_in;
        end

        if (wr_ctl) begin
            st_nxt.ctl.high_overflow_flag  = sfr_wdata_in[HIGH_FLAG_BIT];
            st_nxt.ctl.low_overflow_flag   = sfr_wdata_in[LOW_FLAG_BIT];
            st_nxt.ctl.low_byte_irq_enable = sfr_wdata_in[LOW_IRQ_EN_BIT];
            st_nxt.ctl.split_mode_select   = sfr_wdata_in[SPLIT_BIT];
            st_nxt.ctl.run_control         = sfr_wdata_in[RUN_BIT];
            st_nxt.ctl.ext_clock_select    = sfr_wdata_in[EXT_CLK_BIT];
        end
        // hardware flag sets applied after the control write, so a set beats a software clear
        if (set_high) begin
            st_nxt.ctl.high_overflow_flag = 1'b1;
        end
        if (set_low) begin
            st_nxt.ctl.low_overflow_flag = 1'b1;
        end

        // --------------------------------------------------------
        // read mux
        // --------------------------------------------------------
        // read data, one cycle after the address; unused bits read zero
        case (sfr_addr_in)
            TIMER_CONTROL_ADDR: begin
                st_nxt.rdata = {st_r.ctl.high_overflow_flag, st_r.ctl.low_overflow_flag,
                                st_r.ctl.low_byte_irq_enable, 1'b0,
                                st_r.ctl.split_mode_select, st_r.ctl.run_control,
                                1'b0, st_r.ctl.ext_clock_select};
            end
            RELOAD_LOW_BYTE_ADDR:  st_nxt.rdata = st_r.reload_low_byte;
            RELOAD_HIGH_BYTE_ADDR: st_nxt.rdata = st_r.reload_high_byte;
            COUNT_LOW_BYTE_ADDR:   st_nxt.rdata = st_r.count_low_byte;
            COUNT_HIGH_BYTE_ADDR:  st_nxt.rdata = st_r.count_high_byte;
            default:               st_nxt.rdata = BYTE_RESET;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            // control fields picked from their register positions
            st_r <= '{
                ctl: '{
                    high_overflow_flag:  TIMER_CONTROL_RESET[HIGH_FLAG_BIT],
                    low_overflow_flag:   TIMER_CONTROL_RESET[LOW_FLAG_BIT],
                    low_byte_irq_enable: TIMER_CONTROL_RESET[LOW_IRQ_EN_BIT],
                    split_mode_select:   TIMER_CONTROL_RESET[SPLIT_BIT],
                    run_control:         TIMER_CONTROL_RESET[RUN_BIT],
                    ext_clock_select:    TIMER_CONTROL_RESET[EXT_CLK_BIT]
                },
                reload_low_byte:  BYTE_RESET,
                reload_high_byte: BYTE_RESET,
                count_low_byte:   BYTE_RESET,
                count_high_byte:  BYTE_RESET,
                rdata:            BYTE_RESET,
                presc:            PRESCALE_RESET,
                ext_meta:         1'b0,
                ext_sync:         1'b0,
                ext_prev:         1'b0,
                ext_div:          EXT_DIV_RESET
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sfr_rdata_out          = st_r.rdata;
    assign high_overflow_flag_out = st_r.ctl.high_overflow_flag;
    assign low_overflow_flag_out  = st_r.ctl.low_overflow_flag;
    // level request while the high flag, or the low flag with low-byte irq enable, stands
    assign irq_request_out = timer_irq_enable_in &&
                             (st_r.ctl.high_overflow_flag ||
                              (st_r.ctl.low_byte_irq_enable && st_r.ctl.low_overflow_flag));

endmodule

// *** timer_two_pkg.sv ***
// constants and types for the auto-reload timer
package timer_two_pkg;

    // ------------------------------------------------------------
    // register addresses on the special function register port
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER_CONTROL_ADDR    = 8'hC8;
    localparam logic [7:0] RELOAD_LOW_BYTE_ADDR  = 8'hCA;
    localparam logic [7:0] RELOAD_HIGH_BYTE_ADDR = 8'hCB;
    localparam logic [7:0] COUNT_LOW_BYTE_ADDR   = 8'hCC;
    localparam logic [7:0] COUNT_HIGH_BYTE_ADDR  = 8'hCD;

    // ------------------------------------------------------------
    // timer_control field positions and reset values
    // ------------------------------------------------------------
    localparam int HIGH_FLAG_BIT  = 7;
    localparam int LOW_FLAG_BIT   = 6;
    localparam int LOW_IRQ_EN_BIT = 5;
    localparam int SPLIT_BIT      = 3;
    localparam int RUN_BIT        = 2;
    localparam int EXT_CLK_BIT    = 0;

    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET          = 8'h00;
    localparam logic [7:0] BYTE_MAX            = 8'hFF;

    // ------------------------------------------------------------
    // prescaler counts
    // ------------------------------------------------------------
    localparam int          SYSTEM_CLOCK_DIVIDE  = 12;
    localparam logic [3:0]  PRESCALE_LAST  = 4'(SYSTEM_CLOCK_DIVIDE - 1);
    localparam logic [3:0]  PRESCALE_RESET = 4'h0;
    localparam logic [2:0]  EXT_DIV_RESET  = 3'h0;

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic split_mode_select;
        logic run_control;
        logic ext_clock_select;
    } timer_control_t;

    typedef struct packed {
        timer_control_t ctl;
        logic [7:0]     reload_low_byte;
        logic [7:0]     reload_high_byte;
        logic [7:0]     count_low_byte;
        logic [7:0]     count_high_byte;
        logic [7:0]     rdata;
        logic [3:0]     presc;
        logic           ext_meta;
        logic           ext_sync;
        logic           ext_prev;
        logic [2:0]     ext_div;
    } timer_state_t;

endpackage

// *** timer_two_assertions.sv ***
// port-level checker for the auto-reload timer
`timescale 1ns/1ps
module timer_two_assertions
    import timer_two_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       reset_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic       sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       high_byte_system_clock_select_in,
    input wire logic       low_byte_system_clock_select_in,
    input wire logic       timer_irq_enable_in,
    input wire logic       ext_clock_in,
    input wire logic       irq_request_out,
    input wire logic       high_overflow_flag_out,
    input wire logic       low_overflow_flag_out
);
    // ----
    // properties
    // ----
    logic ctl_wr;
    assign ctl_wr = sfr_wr_in && sfr_addr_in == TIMER_CONTROL_ADDR;
    logic clr_high;
    logic clr_low;
    assign clr_high = ctl_wr && !sfr_wdata_in[HIGH_FLAG_BIT];
    assign clr_low  = ctl_wr && !sfr_wdata_in[LOW_FLAG_BIT];
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    irq_off_a: assert property (!timer_irq_enable_in |-> !irq_request_out)
        else $error("irq raised while disabled");
    irq_high_a: assert property (timer_irq_enable_in && high_overflow_flag_out |-> irq_request_out)
        else $error("high flag without irq");
    high_hold_a: assert property ($fell(high_overflow_flag_out) |-> $past(clr_high))
        else $error("high flag cleared by itself");
    low_hold_a: assert property ($fell(low_overflow_flag_out) |-> $past(clr_low))
        else $error("low flag cleared by itself");
    flag_set_a: assert property (ctl_wr && sfr_wdata_in[7] |=> high_overflow_flag_out)
        else $error("flag write ignored");
    unused_bits_a: assert property (sfr_addr_in == TIMER_CONTROL_ADDR |=> sfr_rdata_out[4] == 1'b0 && sfr_rdata_out[1] == 1'b0)
        else $error("unused control bits nonzero");
    flag_read_a: assert property (sfr_addr_in == TIMER_CONTROL_ADDR |=> sfr_rdata_out[7] == $past(high_overflow_flag_out))
        else $error("flag readback mismatch");
    reload_rb_a: assert property (sfr_wr_in && sfr_addr_in == RELOAD_LOW_BYTE_ADDR ##1 sfr_addr_in == RELOAD_LOW_BYTE_ADDR |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
        else $error("reload readback mismatch");
    cover property ($rose(high_overflow_flag_out));
    cover property ($rose(low_overflow_flag_out));
    cover property ($rose(irq_request_out));
endmodule
bind auto_reload_timer_two timer_two_assertions u_chk (.core_clk_in, .reset_n_in, .sfr_addr_in,
    .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .high_byte_system_clock_select_in,
    .low_byte_system_clock_select_in, .timer_irq_enable_in, .ext_clock_in, .irq_request_out,
    .high_overflow_flag_out, .low_overflow_flag_out);

// *** auto_reload_timer_two_tb.sv ***
// self-checking bench for the auto-reload timer
`timescale 1ns/1ps
module auto_reload_timer_two_tb;
    import timer_two_pkg::*;
    logic       clk, rst_n, wr, hsel, lsel, ien, ext, irq, hf, lf;
    logic [7:0] addr, wdata, rdata, v, w;
    int         fail_count = 0, total_checks = 0, cycles = 0;
    auto_reload_timer_two u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .high_byte_system_clock_select_in(hsel), .low_byte_system_clock_select_in(lsel),
        .timer_irq_enable_in(ien), .ext_clock_in(ext), .irq_request_out(irq),
        .high_overflow_flag_out(hf), .low_overflow_flag_out(lf));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // ----
    // helpers
    // ----
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(string n, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    // idle cycle after each write keeps the strobe from re-rising in one step
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        addr = a; wdata = d; wr = 1;
        @(negedge clk) wr = 0;
        @(negedge clk);
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] r);
        addr = a;
        repeat (2) @(negedge clk);
        r = rdata;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        logic [7:0] ra [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
        foreach (ra[i]) begin
            rd(ra[i], v); chk("reset read", 8'h00, v);
        end
    endtask
    task automatic t_wide();
        lsel = 1; ien = 1;
        wreg(RELOAD_HIGH_BYTE_ADDR, 8'h12);
        wreg(RELOAD_LOW_BYTE_ADDR, 8'h34);
        wreg(COUNT_HIGH_BYTE_ADDR, 8'hFF);
        wreg(COUNT_LOW_BYTE_ADDR, 8'hF0);
        wreg(TIMER_CONTROL_ADDR, 8'h04);
        repeat (30) @(negedge clk);
        chk("wide flag", 8'h01, {7'h0, hf});
        chk("wide irq", 8'h01, {7'h0, irq});
        wreg(TIMER_CONTROL_ADDR, 8'hC0);
        rd(COUNT_HIGH_BYTE_ADDR, v); chk("wide reload", 8'h12, v);
        rd(COUNT_LOW_BYTE_ADDR, v); rd(COUNT_LOW_BYTE_ADDR, w); chk("wide hold", v, w);
        wreg(TIMER_CONTROL_ADDR, 8'h00);
        chk("irq clear", 8'h00, {7'h0, irq});
        wreg(COUNT_HIGH_BYTE_ADDR, 8'h00);
        wreg(COUNT_LOW_BYTE_ADDR, 8'hFE);
        wreg(TIMER_CONTROL_ADDR, 8'h24);
        repeat (3) @(negedge clk);
        chk("low wrap flag", 8'h01, {7'h0, lf});
        chk("no high wrap", 8'h00, {7'h0, hf});
        chk("low wrap irq", 8'h01, {7'h0, irq});
        wreg(TIMER_CONTROL_ADDR, 8'h00);
    endtask
    task automatic t_split();
        hsel = 1;
        wreg(RELOAD_LOW_BYTE_ADDR, 8'h80);
        wreg(COUNT_LOW_BYTE_ADDR, 8'hFF);
        wreg(COUNT_HIGH_BYTE_ADDR, 8'hFF);
        wreg(TIMER_CONTROL_ADDR, 8'h08);
        repeat (10) @(negedge clk);
        chk("split low flag", 8'h01, {7'h0, lf});
        chk("split high flag", 8'h00, {7'h0, hf});
        chk("low irq off", 8'h00, {7'h0, irq});
        rd(COUNT_HIGH_BYTE_ADDR, v); chk("high stopped", 8'hFF, v);
        rd(COUNT_LOW_BYTE_ADDR, v); chk("low reloaded", 8'h01, {7'h0, v >= 8'h80 && v < 8'hA0});
        wreg(TIMER_CONTROL_ADDR, 8'h68);
        chk("low irq on", 8'h01, {7'h0, irq});
        wreg(TIMER_CONTROL_ADDR, 8'h0C);
        repeat (3) @(negedge clk);
        chk("high wrap", 8'h01, {7'h0, hf});
        chk("high irq", 8'h01, {7'h0, irq});
    endtask
    task automatic t_clocks();
        lsel = 0; hsel = 0;
        wreg(TIMER_CONTROL_ADDR, 8'h0C);
        wreg(COUNT_LOW_BYTE_ADDR, 8'h00);
        wreg(COUNT_HIGH_BYTE_ADDR, 8'h00);
        repeat (120) @(negedge clk);
        rd(COUNT_LOW_BYTE_ADDR, v); chk("div12", 8'h01, {7'h0, v >= 8'd9 && v <= 8'd11});
        rd(COUNT_HIGH_BYTE_ADDR, v); chk("high div12", 8'h01, {7'h0, v >= 8'd9 && v <= 8'd11});
        wreg(TIMER_CONTROL_ADDR, 8'h0D);
        wreg(COUNT_LOW_BYTE_ADDR, 8'h00);
        wreg(COUNT_HIGH_BYTE_ADDR, 8'h00);
        repeat (64) begin
            ext = 1; repeat (2) @(negedge clk);
            ext = 0; repeat (2) @(negedge clk);
        end
        repeat (8) @(negedge clk);
        rd(COUNT_LOW_BYTE_ADDR, v); chk("ext div8", 8'h08, v);
        rd(COUNT_HIGH_BYTE_ADDR, v); chk("high ext div8", 8'h08, v);
    endtask
    initial begin
        rst_n = 0; wr = 0; addr = 0; wdata = 0; hsel = 0; lsel = 0; ien = 0; ext = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        t_reset();
        t_wide();
        t_split();
        t_clocks();
        tally_and_finish();
    end
endmodule
